/* File: verilog/dcs_top.sv */
// upper bits of control word one and status word one, with serial port
// assumes the serial master idles clock low and samples on rising edges
//
// Contract
// R1: writing enable one moves the device from standby toward active.
// R2: writing enable zero enters standby and clears all control bits.
// R3: after power-on reset the device sits in standby.
// R4: top status bit always reads one; all-zero or all-one frames invalid.
// R5: over-current on a highside output sets its flag, output off.
// R6: with retry enabled the output comes back after a duty-set delay.
// R7: one retry may run even if retry enable is zero.
// R8: supply over- or undervoltage sets its flag and disables outputs.
// R9: outputs return by themselves when the supply recovers.
// R10: thermal shutdown sets its flag and switches all outputs off.
// R11: outputs stay off until reset bit clears thermal shutdown flag.
// R12: temperature warning is reported only, never switches outputs.
// R13: leaving standby starts settle timer; outputs held, not-ready set.
// R14: not-ready clears when the settle time expires.
// R15: status bit zero is the NOR of status bits 1 to 22; the code also NORs in status_zero_faults.
// R16: fault flags stay latched until reset bit or standby; supply follows.
`timescale 1ns/1ns
`default_nettype none
module dcs_top
    import dcs_pkg::*;
#(
    parameter int SETTLE_CYC = SETTLE_US * CLK_MHZ
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    input wire logic [4:0] hs_request,
    input wire logic [4:0] oc_detect,
    input wire logic overvolt_detect,
    input wire logic undervolt_detect,
    input wire logic overtemp_detect,
    input wire logic tempwarn_detect,
    input wire logic retry_duty_long,
    input wire logic fault_reset,
    input wire logic [16:0] status_one_low,
    input wire logic [21:0] status_zero_faults,
    output logic [23:0] control_word_one,
    output logic [4:0] oc_flag,
    output logic device_active,
    output logic highside_output_7,
    output logic highside_output_8,
    output logic highside_output_9,
    output logic highside_output_10,
    output logic highside_output_11
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] sy1;
        logic [11:0] sy2;
        logic sclk_d;
        logic csn_d;
        dcs_mode_t mode;
        logic [SETTLE_W-1:0] settle_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic [23:0] shin;
        logic [23:0] shout;
        logic [4:0] bitcnt;
        logic [23:0] ctrl;
        logic thermal_shutdown_flag;
        logic tw;
        logic [4:0] drive;
    } dcs_top_st_t;

    localparam logic [SETTLE_W-1:0] SETTLE_LOAD =
        SETTLE_W'(SETTLE_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_LOAD = TICK_W'(RETRY_TICK_CYC - 1);

    dcs_top_st_t st_r;
    dcs_top_st_t st_nxt;
    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    logic frame_write;
    logic standby;
    logic allowed;
    logic tick;
    logic [5:0] own_status;
    logic [23:0] status_w;
    logic [4:0] chan_off;
    logic [4:0] chan_flag;

    // ------------------------------------------------------------
    // frame edges and status word
    // ------------------------------------------------------------
    assign sclk_rise = st_r.sy2[SY_SCLK] && !st_r.sclk_d;
    assign sclk_fall = !st_r.sy2[SY_SCLK] && st_r.sclk_d;
    assign csn_fall = !st_r.sy2[SY_CSN] && st_r.csn_d;
    assign csn_rise = st_r.sy2[SY_CSN] && !st_r.csn_d;
    assign frame_write = csn_rise && (st_r.bitcnt == FRAME_LEN)
        && (st_r.shin[BIT_SEL] == SEL_WORD_ONE);
    assign standby = (st_r.mode == DCS_STANDBY);
    assign tick = (st_r.tick_cnt == '0);
    // supply flags follow the synchronised supply condition
    assign own_status = {1'b1, st_r.sy2[SY_OV], st_r.sy2[SY_UV], // [R4] [R16]
        st_r.thermal_shutdown_flag, st_r.tw, (st_r.mode == DCS_SETTLE)}; // [R13]
    assign status_w = {own_status, status_one_low,
        ~|{own_status[4:0], status_one_low, status_zero_faults}}; // [R15]
    assign allowed = (st_r.mode == DCS_ACTIVE) && !st_r.sy2[SY_OV]
        && !st_r.sy2[SY_UV] && !st_r.thermal_shutdown_flag; // [R8] [R9] [R10] [R13]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.sy1 = {oc_detect, tempwarn_detect, overtemp_detect,
            undervolt_detect, overvolt_detect, spi_mosi, spi_csn, spi_sclk};
        st_nxt.sy2 = st_r.sy1;
        st_nxt.sclk_d = st_r.sy2[SY_SCLK];
        st_nxt.csn_d = st_r.sy2[SY_CSN];
        st_nxt.tick_cnt = tick ? TICK_LOAD : st_r.tick_cnt - TICK_W'(1);
        // serial shifter
        if (csn_fall) begin
            st_nxt.shout = status_w; // [R4]
            st_nxt.bitcnt = 5'h00;
        end else if (!st_r.sy2[SY_CSN]) begin
            if (sclk_rise) begin
                st_nxt.shin = {st_r.shin[22:0], st_r.sy2[SY_MOSI]};
                if (st_r.bitcnt != 5'h1F) begin
                    st_nxt.bitcnt = st_r.bitcnt + 5'h01;
                end
            end
            if (sclk_fall) begin
                st_nxt.shout = {st_r.shout[22:0], 1'b0};
            end
        end
        // mode sequence
        unique case (st_r.mode)
            DCS_STANDBY: begin
                if (frame_write && st_r.shin[BIT_ENABLE]) begin
                    st_nxt.mode = DCS_SETTLE; // [R1] [R13]
                    st_nxt.settle_cnt = SETTLE_LOAD;
                end
            end
            DCS_SETTLE: begin
                if (st_r.settle_cnt == '0) begin
                    st_nxt.mode = DCS_ACTIVE; // [R14]
                end else begin
                    st_nxt.settle_cnt = st_r.settle_cnt - SETTLE_W'(1);
                end
            end
            DCS_ACTIVE: begin
            end
        endcase
        if (frame_write) begin
            st_nxt.ctrl = st_r.shin;
            if (!st_r.shin[BIT_ENABLE]) begin
                st_nxt.ctrl = CTRL_RESET; // [R2]
                st_nxt.mode = DCS_STANDBY; // [R2]
            end
        end
        // latched thermal flags, set wins over clear
        if (fault_reset || standby) begin
            st_nxt.thermal_shutdown_flag = 1'b0; // [R11] [R16]
            st_nxt.tw = 1'b0; // [R16]
        end
        if (st_r.sy2[SY_OT]) begin
            st_nxt.thermal_shutdown_flag = 1'b1; // [R10]
        end
        // warning never feeds the output gating
        if (st_r.sy2[SY_TW]) begin
            st_nxt.tw = 1'b1; // [R12]
        end
        st_nxt.drive = hs_request & ~chan_off & {HS_NUM{allowed}}; // [R5]
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r.sy1 <= SY_RESET;
            st_r.sy2 <= SY_RESET;
            st_r.sclk_d <= 1'b0;
            st_r.csn_d <= 1'b1;
            st_r.mode <= DCS_STANDBY; // [R3]
            st_r.settle_cnt <= '0;
            st_r.tick_cnt <= '0;
            st_r.shin <= '0;
            st_r.shout <= '0;
            st_r.bitcnt <= '0;
            st_r.ctrl <= CTRL_RESET;
            st_r.thermal_shutdown_flag <= 1'b0;
            st_r.tw <= 1'b0;
            st_r.drive <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // over-current channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < HS_NUM; i++) begin : g_chan
        dcs_chan_if u_if (
            .mclk(mclk),
            .rst_b(rst_b)
        );
        assign u_if.tick = tick;
        assign u_if.oc_evt = st_r.sy2[SY_OC + i]; // [R5]
        assign u_if.retry_en = st_r.ctrl[BIT_RETRY_LO + i]; // [R6]
        assign u_if.duty_long = retry_duty_long;
        assign u_if.clear = fault_reset || standby; // [R16]
        assign chan_off[i] = u_if.off;
        assign chan_flag[i] = u_if.flag;
        dcs_oc_chan u_ch (
            .p(u_if.chan)
        );
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spi_miso_o = st_r.shout[FRAME_BITS-1];
    assign spi_miso_oe = !st_r.sy2[SY_CSN];
    assign control_word_one = st_r.ctrl;
    assign oc_flag = chan_flag;
    assign device_active = !standby;
    assign highside_output_7 = st_r.drive[0];
    assign highside_output_8 = st_r.drive[1];
    assign highside_output_9 = st_r.drive[2];
    assign highside_output_10 = st_r.drive[3];
    assign highside_output_11 = st_r.drive[4];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_write_on;
        frame_write && st_r.shin[BIT_ENABLE];
    endsequence
    sequence s_write_off;
        frame_write && !st_r.shin[BIT_ENABLE];
    endsequence
    sequence s_clean_active;
        allowed && (chan_off == 5'h00) && $stable(hs_request);
    endsequence
    // every gate but the warning open, so only the warning could block
    sequence s_warn_clean;
        st_r.tw && (st_r.mode == DCS_ACTIVE) && !st_r.sy2[SY_OV]
            && !st_r.sy2[SY_UV] && !st_r.thermal_shutdown_flag && (chan_off == 5'h00);
    endsequence
    sequence s_no_fault;
        (own_status[4:0] == 5'h00) && (status_one_low == 17'h00000)
            && (status_zero_faults == 22'h000000);
    endsequence

    AST_ENABLE_ON: assert property ( // [R1]
        s_write_on ##0 standby |=> st_r.mode == DCS_SETTLE)
        else $error("enable write did not leave standby");
    AST_SETTLE_START: assert property ( // [R13]
        s_write_on ##0 standby |=> st_r.settle_cnt == SETTLE_LOAD)
        else $error("settle timer not started on enable");
    AST_ENABLE_OFF: assert property ( // [R2]
        s_write_off |=> standby && (st_r.ctrl == CTRL_RESET))
        else $error("disable write did not clear control");
    AST_RESET_STANDBY: assert property ( // [R3]
        @(posedge mclk) disable iff (1'b0) !rst_b |=> standby)
        else $error("not in standby after reset");
    AST_ALWAYS_ONE: assert property ( // [R4]
        csn_fall |=> spi_miso_o && spi_miso_oe)
        else $error("top status bit not one");
    AST_OC_GATE: assert property ( // [R5]
        chan_off != 5'h00 |=> (st_r.drive & $past(chan_off)) == 5'h00)
        else $error("output driven while its channel is off");
    AST_SUPPLY_OFF: assert property ( // [R8]
        (st_r.sy2[SY_OV] || st_r.sy2[SY_UV]) |=> st_r.drive == 5'h00)
        else $error("outputs on during supply fault");
    AST_SUPPLY_FLAG: assert property ( // [R8]
        (status_w[ST_OV] == st_r.sy2[SY_OV])
        && (status_w[ST_UV] == st_r.sy2[SY_UV]))
        else $error("supply flag does not follow supply");
    AST_SUPPLY_BACK: assert property ( // [R9]
        s_clean_active [*2] |=> st_r.drive == $past(hs_request))
        else $error("outputs not restored after supply recovery");
    AST_TSD_SET: assert property ( // [R10]
        st_r.sy2[SY_OT] |=> st_r.thermal_shutdown_flag ##1 st_r.drive == 5'h00)
        else $error("thermal shutdown not taken");
    AST_TSD_HOLD: assert property ( // [R11]
        st_r.thermal_shutdown_flag && !fault_reset && !standby |=> st_r.thermal_shutdown_flag)
        else $error("thermal flag dropped without reset bit");
    AST_TSD_CLEAR: assert property ( // [R11]
        st_r.thermal_shutdown_flag && fault_reset && !st_r.sy2[SY_OT] |=> !st_r.thermal_shutdown_flag)
        else $error("reset bit did not clear thermal flag");
    AST_WARN_SET: assert property ( // [R12]
        st_r.sy2[SY_TW] |=> st_r.tw)
        else $error("temperature warning not reported");
    AST_WARN_ONLY: assert property ( // [R12]
        s_warn_clean |=> st_r.drive == $past(hs_request))
        else $error("temperature warning disabled outputs");
    AST_SETTLE_HOLD: assert property ( // [R13]
        st_r.mode == DCS_SETTLE
        |-> status_w[ST_NR] ##1 st_r.drive == 5'h00)
        else $error("outputs on while charge pump settles");
    AST_SETTLE_END: assert property ( // [R14]
        (st_r.mode == DCS_SETTLE) && (st_r.settle_cnt == '0) && !frame_write
        |=> (st_r.mode == DCS_ACTIVE) && !status_w[ST_NR])
        else $error("not-ready did not clear at settle end");
    AST_NOERR: assert property ( // [R15]
        st_r.thermal_shutdown_flag |-> !status_w[ST_NOERR])
        else $error("no-error bit set while fault flag set");
    AST_NOERR_SET: assert property ( // [R15]
        s_no_fault |-> status_w[ST_NOERR])
        else $error("no-error bit clear with no fault flag");
    AST_STANDBY_CLEAR: assert property ( // [R16]
        standby && !st_r.sy2[SY_OT] && (st_r.sy2[SY_OC +: HS_NUM] == 5'h00)
        |=> !st_r.thermal_shutdown_flag && (chan_flag == 5'h00))
        else $error("flags not cleared in standby");
endmodule
`default_nettype wire

/* File: verilog/dcs_pkg.sv */
// constants and types of the driver configuration and status upper bits
// assumes a single 100 MHz clock and a 24-bit serial frame
`default_nettype none
package dcs_pkg;
    // ------------------------------------------------------------
    // frame and field layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] FRAME_LEN = 5'h18;
    localparam int HS_NUM = 5;
    localparam int BIT_SEL = 0;
    localparam logic SEL_WORD_ONE = 1'h1;
    localparam int BIT_ENABLE = 23;
    localparam int BIT_RETRY_LO = 18;
    localparam int ST_ALWAYS1 = 23;
    localparam int ST_OV = 22;
    localparam int ST_UV = 21;
    localparam int ST_TSD = 20;
    localparam int ST_TW = 19;
    localparam int ST_NR = 18;
    localparam int ST_NOERR = 0;
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    // ------------------------------------------------------------
    // synchroniser lanes
    // ------------------------------------------------------------
    localparam int SY_W = 12;
    localparam int SY_SCLK = 0;
    localparam int SY_CSN = 1;
    localparam int SY_MOSI = 2;
    localparam int SY_OV = 3;
    localparam int SY_UV = 4;
    localparam int SY_OT = 5;
    localparam int SY_TW = 6;
    localparam int SY_OC = 7;
    localparam logic [11:0] SY_RESET = 12'h002;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_W = 24;
    localparam int RETRY_TICK_US = 10;
    localparam int RETRY_TICK_CYC = RETRY_TICK_US * CLK_MHZ;
    localparam int TICK_W = 10;
    localparam logic [3:0] RETRY_OFF_SHORT = 4'h3;
    localparam logic [3:0] RETRY_OFF_LONG = 4'hB;
    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCS_STANDBY = 3'h1,
        DCS_SETTLE = 3'h2,
        DCS_ACTIVE = 3'h4
    } dcs_mode_t;
endpackage
`default_nettype wire

/* File: verilog/dcs_chan_if.sv */
// per-output over-current channel signals between top and channel
// assumes the channel runs on the top's clock and reset
`timescale 1ns/1ns
`default_nettype none
interface dcs_chan_if (
    input wire logic mclk,
    input wire logic rst_b
);
    logic tick;
    logic oc_evt;
    logic retry_en;
    logic duty_long;
    logic clear;
    logic off;
    logic flag;
    modport chan (input mclk, rst_b, tick, oc_evt, retry_en, duty_long,
        clear, output off, flag);
    modport ctl (output tick, oc_evt, retry_en, duty_long, clear,
        input off, flag);
endinterface
`default_nettype wire

/* File: verilog/dcs_oc_chan.sv */
// over-current latch and automatic retry of one highside output
// assumes oc_evt is already synchronised and tick is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module dcs_oc_chan
    import dcs_pkg::*;
(
    dcs_chan_if.chan p
);
    typedef struct packed {
        logic flag;
        logic off;
        logic pend;
        logic [3:0] cnt;
    } dcs_chan_st_t;

    dcs_chan_st_t st_r;
    dcs_chan_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (p.clear) begin
            st_nxt.flag = 1'b0;
            st_nxt.off = 1'b0;
            st_nxt.pend = 1'b0;
        end
        if (p.oc_evt) begin
            // set wins over a clear in the same cycle
            st_nxt.flag = 1'b1; // [R5]
            st_nxt.off = 1'b1; // [R5]
            // enable is taken at the event, so a later clear of it still
            // lets the pending retry run once
            st_nxt.pend = p.retry_en | st_r.pend; // [R7]
            st_nxt.cnt = p.duty_long ? RETRY_OFF_LONG : RETRY_OFF_SHORT; // [R6]
        end else if (st_r.off && st_r.pend && p.tick) begin
            if (st_r.cnt == 4'h0) begin
                st_nxt.off = 1'b0; // [R6]
                st_nxt.pend = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge p.mclk) begin
        if (!p.rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign p.off = st_r.off;
    assign p.flag = st_r.flag;

    default clocking cb @(posedge p.mclk); endclocking
    default disable iff (!p.rst_b);

    AST_OC_OFF: assert property (p.oc_evt |=> p.off && p.flag) // [R5]
        else $error("over-current did not switch output off");
    AST_RETRY: assert property ( // [R6]
        st_r.off && st_r.pend && p.tick && (st_r.cnt == 4'h0) && !p.oc_evt
        && !p.clear |=> !p.off)
        else $error("retry did not reactivate output");
    AST_NO_RETRY: assert property ( // [R6]
        p.off && !st_r.pend && !p.clear |=> p.off)
        else $error("output came back without retry");
endmodule
`default_nettype wire

/* File: verification/dcs_spi_master.sv */
// serial master model standing in for the host microcontroller
// assumes the device samples rising sclk edges and shifts on falling ones
`timescale 1ns/1ns
`default_nettype none
module dcs_spi_master (
    output logic sclk,
    output logic csn,
    output logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    output logic bad_frame
);
    logic last;

    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        mosi = 1'b0;
        bad_frame = 1'b0;
        last = 1'b0;
    end

    // ------------------------------------------------------------
    // one 24-bit frame, msb first; slow stretches each low phase
    // ------------------------------------------------------------
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx,
        input int slow);
        csn = 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            mosi = tx[i];
            #(62 + slow);
            sclk = 1'b1;
            // an undriven line is not trusted to keep its level
            rx[i] = miso_oe ? miso_o : ~last;
            last = rx[i];
            #63;
            sclk = 1'b0;
        end
        #60;
        csn = 1'b1;
        mosi = ~mosi;
        // a flat frame means a broken supply or link
        bad_frame = (rx == 24'h000000) || (rx == 24'hFFFFFF);
        #100;
    endtask
endmodule
`default_nettype wire

/* File: verification/driver_cfg_status_upper_bits_tb.sv */
// self-checking bench of the upper control and status bits
// assumes dcs_top and the serial master model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module driver_cfg_status_upper_bits_tb;
    import dcs_pkg::*;
    localparam int SC = 200;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, csn, mosi, miso_o, miso_oe, bad_frame;
    logic [4:0] hs_request = 5'h00;
    logic [4:0] oc_detect = 5'h00;
    logic ov = 1'b0, uv = 1'b0, ot = 1'b0, tw = 1'b0;
    logic duty = 1'b0, fault_reset = 1'b0;
    logic [16:0] st_low = 17'h00000;
    logic [21:0] st_zero = 22'h000000;
    logic [23:0] cw;
    logic [4:0] oc_flag, hs;
    logic active, o7, o8, o9, o10, o11;
    logic [23:0] s;
    int failures = 0;
    int total_checks = 0;
    int n;

    assign hs = {o11, o10, o9, o8, o7};
    always #5 mclk = ~mclk;

    dcs_spi_master m (.sclk(sclk), .csn(csn), .mosi(mosi),
        .miso_o(miso_o), .miso_oe(miso_oe), .bad_frame(bad_frame));

    dcs_top #(.SETTLE_CYC(SC)) uut (.mclk(mclk), .rst_b(rst_b),
        .spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi),
        .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
        .hs_request(hs_request), .oc_detect(oc_detect),
        .overvolt_detect(ov), .undervolt_detect(uv),
        .overtemp_detect(ot), .tempwarn_detect(tw),
        .retry_duty_long(duty), .fault_reset(fault_reset),
        .status_one_low(st_low), .status_zero_faults(st_zero),
        .control_word_one(cw), .oc_flag(oc_flag), .device_active(active),
        .highside_output_7(o7), .highside_output_8(o8),
        .highside_output_9(o9), .highside_output_10(o10),
        .highside_output_11(o11));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] e,
        input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask

    // status read sends word zero, which this block ignores
    task automatic rd(input logic [23:0] mask, input logic [23:0] e);
        m.xfer(24'h000000, s, 0);
        chk("frame valid", 24'h000000, {23'h0, bad_frame});
        chk("status", e, s & mask);
        step(1);
    endtask

    task automatic wr(input logic [23:0] w, input int slow);
        logic [23:0] r;
        m.xfer(w, r, slow);
        step(1);
    endtask

    // bounded wait for the output drive pattern
    task automatic wait_hs(input logic [4:0] e, input int lim);
        n = 0;
        while (hs !== e && n < lim) begin
            step(1);
            n++;
        end
        chk("highside", {19'h0, e}, {19'h0, hs});
        if (hs !== e) begin
            end_sim();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int lo, hi;
        step(5);
        rst_b = 1'b1;
        hs_request = 5'h1F;
        step(5);
        chk("active", 24'h0, {23'h0, active});
        chk("highside", 24'h0, {19'h0, hs});
        rd(24'h800000, 24'h800000);
        // enable with retry for the first output only
        wr(24'h840001, 40);
        chk("control", 24'h840001, cw);
        chk("active", 24'h1, {23'h0, active});
        chk("highside", 24'h0, {19'h0, hs});
        step(5);
        rd(24'hFC0001, 24'h840000);
        chk("control", 24'h840001, cw); // word zero ignored
        rd(24'hFC0001, 24'h800001);
        wait_hs(5'h1F, 10);
        st_zero = 22'h000001;
        rd(24'hFC0001, 24'h800000);
        st_zero = 22'h000000;
        st_low = 17'h00001;
        rd(24'hFFFFFF, 24'h800002);
        st_low = 17'h00000;
        // over-current with short and long retry
        for (int d = 0; d < 2; d++) begin
            duty = d[0];
            oc_detect = d ? 5'h01 : 5'h03;
            wait_hs(5'h1C, 10);
            step(10);
            oc_detect = 5'h00;
            lo = (d ? RETRY_OFF_LONG : RETRY_OFF_SHORT) * RETRY_TICK_CYC;
            hi = lo + RETRY_TICK_CYC + 10;
            wait_hs(5'h1D, hi);
            chk("retry late", 24'h1, {23'h0, n >= lo - 5});
        end
        chk("oc flag", 24'h03, {19'h0, oc_flag});
        chk("no retry", 24'h0, {23'h0, o8});
        fault_reset = 1'b1;
        step(2);
        fault_reset = 1'b0;
        wait_hs(5'h1F, 10);
        chk("oc flag", 24'h0, {19'h0, oc_flag});
        // supply faults follow the supply
        for (int k = 0; k < 2; k++) begin
            ov = (k == 0);
            uv = (k == 1);
            wait_hs(5'h00, 10);
            rd(24'hFC0001, k ? 24'hA00000 : 24'hC00000);
            ov = 1'b0;
            uv = 1'b0;
            wait_hs(5'h1F, 10);
            rd(24'hFC0001, 24'h800001);
        end
        // warning only reports, and stays latched
        tw = 1'b1;
        step(20);
        tw = 1'b0;
        chk("highside", 24'h1F, {19'h0, hs});
        rd(24'hFC0001, 24'h880000);
        // thermal shutdown holds outputs off until the reset bit
        ot = 1'b1;
        wait_hs(5'h00, 10);
        step(5);
        ot = 1'b0;
        step(50);
        chk("highside", 24'h0, {19'h0, hs});
        rd(24'hFC0001, 24'h980000);
        fault_reset = 1'b1;
        step(2);
        fault_reset = 1'b0;
        wait_hs(5'h1F, 10);
        rd(24'hFC0001, 24'h800001);
        // disable clears everything
        wr(24'h000001, 0);
        chk("control", 24'h0, cw);
        chk("active", 24'h0, {23'h0, active});
        chk("highside", 24'h0, {19'h0, hs});
        end_sim();
    end
endmodule
`default_nettype wire
